// *** rtmc_defs.svh ***
// Offsets, field positions and reset values for the flag-override and reset mode code handler.
`ifndef RTMC_DEFS_SVH
`define RTMC_DEFS_SVH
`define RTMC_OFS_STATUS_BITS  8'h1a
`define RTMC_OFS_BIT_WORD     8'h1e
`define RTMC_OFS_CONFIG       8'h17
`define RTMC_MC_OVERRIDE      5'h07
`define RTMC_MC_RESET         5'h08
`define RTMC_BROADCAST_FLAG_ADDR       5'h1f
`define RTMC_BIT_TF_INHIBIT   0
`define RTMC_SW_TF_BIT        0
`define RTMC_CFG_UNDEFINED_MODECODE_INVALID       0
`define RTMC_CFG_SOFT_RESET   1
`define RTMC_ST_ME            10
`define RTMC_ST_BCR           4
`define RTMC_ST_BUSY          3
`define RTMC_ST_TF            0
`define RTMC_DESC_DESCRIPTOR_ACCESSED_FLAG        0
`define RTMC_DESC_BROADCAST_FLAG       1
`define RTMC_DESC_DPB         2
`define RTMC_MI_RECEIVING_BUS_FLAG         0
`define RTMC_MI_MESSAGE_ERROR_FLAG          1
`define RTMC_MI_ILLEGAL_COMMAND_FLAG         2
`define RTMC_MI_RT_TO_RT_FLAG          3
`define RTMC_MI_WORD_COUNT_ERROR_FLAG        4
`define RTMC_MI_ERR_MASK      16'h001e
`define RTMC_ZERO16           16'h0000
`endif

// *** rtmc_pkg.sv ***
// Types for the flag-override and reset mode code handler.
package rtmc_pkg;
    typedef enum logic [2:0] {
        RTMC_OUT_IGNORE,
        RTMC_OUT_DEFAULT,
        RTMC_OUT_INFORM,
        RTMC_OUT_ILLEGAL,
        RTMC_OUT_TRAIL
    } rtmc_outcome_t;
endpackage

// *** rtmc_modecode.sv ***
// Remote terminal handler for the flag-override and terminal-reset mode commands.
`timescale 1ns/1ps
`default_nettype none
`include "rtmc_defs.svh"
// Function
// - Override command clears ME, then sends status.
// - Broadcast override sets BCR, sends no status.
// - Override clears flag inhibit in test word.
// - Uninhibited: status TF follows host TF bit.
// - Default response descriptor and info word updates.
// - Invalid command, or undefined-invalid one without trailing word, is ignored.
// - Undefined-invalid setting overrides illegal table bit.
// - Legal undefined command gets in-form response.
// - Illegalized undefined command sets ME and flags.
// - Trailing data word: no status, errors set.
// - Reset command clears ME, status unless broadcast.
// - After reset status, clear ME, Busy, BCR.
// - Reset command zeroes the test word.
// - Reset command cancels both transmitter shutdowns.
// - Reset command clears the flag inhibit.
// - Reset command keeps host configuration registers.
module rtmc_modecode
    import rtmc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Decoded command from the receiver
    input  wire logic        cmd_valid,
    input  wire logic        cmd_error,
    input  wire logic [4:0]  cmd_rt_addr,
    input  wire logic        cmd_tr,
    input  wire logic [4:0]  cmd_mode_code,
    input  wire logic        cmd_trailing_data,
    input  wire logic        cmd_bus_b,
    input  wire logic        cmd_illegal_bit,
    input  wire logic [4:0]  own_rt_addr,
    // Status transmit handshake and the flag inhibit, shutdown and busy set strobes
    input  wire logic        status_sent,
    input  wire logic        tf_inhibit_set,
    input  wire logic        shutdown_set_a,
    input  wire logic        shutdown_set_b,
    input  wire logic        busy_set,
    // Register port
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // Results
    output logic             status_tx_req,
    output logic      [15:0] status_word,
    output logic             desc_wr,
    output logic      [15:0] desc_word,
    output logic             msg_info_wr,
    output logic      [15:0] msg_info_word,
    output logic             message_complete_irq,
    output logic             broadcast_msg_irq,
    output logic             illegal_command_irq,
    output logic             message_error_irq,
    output logic             tx_shutdown_a,
    output logic             tx_shutdown_b,
    output logic             rt_reset_pending
);
    logic [15:0]   status_bits_r;
    logic [15:0]   bit_word_r;
    logic [15:0]   config_r;
    logic [15:0]   int_status_r;
    logic [15:0]   desc_r;
    logic          reset_wait_r;
    logic          broadcast_flag;
    logic          accept;
    rtmc_outcome_t outcome;

    assign broadcast_flag  = (cmd_rt_addr == `RTMC_BROADCAST_FLAG_ADDR);
    assign accept = cmd_valid && !cmd_error && (broadcast_flag || cmd_rt_addr == own_rt_addr);

    // Outcome selection; the trailing data word check wins over every other case.
    always_comb begin
        outcome = RTMC_OUT_IGNORE;
        if (accept && (cmd_mode_code == `RTMC_MC_OVERRIDE || cmd_mode_code == `RTMC_MC_RESET)) begin
            if (cmd_trailing_data) begin
                outcome = RTMC_OUT_TRAIL;
            end else if (cmd_tr) begin
                outcome = RTMC_OUT_DEFAULT;
            end else if (config_r[`RTMC_CFG_UNDEFINED_MODECODE_INVALID]) begin
                outcome = RTMC_OUT_IGNORE;
            end else if (cmd_illegal_bit) begin
                outcome = RTMC_OUT_ILLEGAL;
            end else begin
                outcome = RTMC_OUT_INFORM;
            end
        end
    end

    logic do_override;
    logic do_reset;
    assign do_override = (outcome == RTMC_OUT_DEFAULT) && (cmd_mode_code == `RTMC_MC_OVERRIDE);
    assign do_reset    = (outcome == RTMC_OUT_DEFAULT) && (cmd_mode_code == `RTMC_MC_RESET);

    // Host registers; configuration is only ever changed by the host.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_bits_r <= `RTMC_ZERO16;
            config_r      <= `RTMC_ZERO16;
        end else if (reg_wr) begin
            if (reg_addr == `RTMC_OFS_STATUS_BITS)
                status_bits_r <= reg_wdata;
            if (reg_addr == `RTMC_OFS_CONFIG)
                config_r <= reg_wdata;
        end
    end

    // Test word; a command clear outranks a host write but a new inhibit set wins.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || (reg_wr && reg_addr == `RTMC_OFS_CONFIG && reg_wdata[`RTMC_CFG_SOFT_RESET])) begin
            bit_word_r <= `RTMC_ZERO16;
        end else begin
            if (do_reset)
                bit_word_r <= `RTMC_ZERO16;
            else if (do_override)
                bit_word_r[`RTMC_BIT_TF_INHIBIT] <= 1'b0;
            else if (reg_wr && reg_addr == `RTMC_OFS_BIT_WORD)
                bit_word_r <= reg_wdata;
            if (tf_inhibit_set)
                bit_word_r[`RTMC_BIT_TF_INHIBIT] <= 1'b1;
        end
    end

    // Internal status register bits.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            int_status_r <= `RTMC_ZERO16;
        end else begin
            if (reset_wait_r && (status_sent || int_status_r[`RTMC_ST_BCR])) begin
                int_status_r[`RTMC_ST_ME]   <= 1'b0;
                int_status_r[`RTMC_ST_BUSY] <= 1'b0;
                int_status_r[`RTMC_ST_BCR]  <= 1'b0;
            end
            if (busy_set)
                int_status_r[`RTMC_ST_BUSY] <= 1'b1;
            case (outcome)
                RTMC_OUT_DEFAULT, RTMC_OUT_INFORM: begin
                    int_status_r[`RTMC_ST_ME]  <= 1'b0;
                    int_status_r[`RTMC_ST_BCR] <= broadcast_flag;
                end
                RTMC_OUT_ILLEGAL: begin
                    int_status_r[`RTMC_ST_ME]  <= 1'b1;
                    int_status_r[`RTMC_ST_BCR] <= broadcast_flag;
                end
                RTMC_OUT_TRAIL: begin
                    int_status_r[`RTMC_ST_ME] <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Reset command wait: cleared once its status has gone, or at once when broadcast.
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            reset_wait_r <= 1'b0;
        else if (do_reset)
            reset_wait_r <= 1'b1;
        else if (status_sent || int_status_r[`RTMC_ST_BCR])
            reset_wait_r <= 1'b0;
    end

    // Transmitter shutdown; the reset command overrides it on both buses.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_shutdown_a <= 1'b0;
            tx_shutdown_b <= 1'b0;
        end else if (do_reset) begin
            tx_shutdown_a <= 1'b0;
            tx_shutdown_b <= 1'b0;
        end else begin
            if (shutdown_set_a)
                tx_shutdown_a <= 1'b1;
            if (shutdown_set_b)
                tx_shutdown_b <= 1'b1;
        end
    end

    // Status word request and composition.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_tx_req <= 1'b0;
            status_word   <= `RTMC_ZERO16;
        end else begin
            status_tx_req <= (outcome != RTMC_OUT_IGNORE) && (outcome != RTMC_OUT_TRAIL) && !broadcast_flag;
            status_word <= int_status_r;
            status_word[`RTMC_ST_TF] <= status_bits_r[`RTMC_SW_TF_BIT] &&
                                        !bit_word_r[`RTMC_BIT_TF_INHIBIT];
        end
    end

    // Descriptor and message-info writes with interrupt strobes; ignored messages write nothing.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            desc_r               <= `RTMC_ZERO16;
            desc_wr              <= 1'b0;
            desc_word            <= `RTMC_ZERO16;
            msg_info_wr          <= 1'b0;
            msg_info_word        <= `RTMC_ZERO16;
            message_complete_irq <= 1'b0;
            broadcast_msg_irq    <= 1'b0;
            illegal_command_irq  <= 1'b0;
            message_error_irq    <= 1'b0;
        end else begin
            desc_wr              <= 1'b0;
            msg_info_wr          <= 1'b0;
            message_complete_irq <= 1'b0;
            broadcast_msg_irq    <= 1'b0;
            illegal_command_irq  <= 1'b0;
            message_error_irq    <= 1'b0;
            if (outcome != RTMC_OUT_IGNORE) begin
                desc_r[`RTMC_DESC_DPB]   <= ~desc_r[`RTMC_DESC_DPB];
                desc_r[`RTMC_DESC_DESCRIPTOR_ACCESSED_FLAG]  <= (outcome != RTMC_OUT_DEFAULT);
                desc_r[`RTMC_DESC_BROADCAST_FLAG] <= (outcome != RTMC_OUT_TRAIL) && broadcast_flag;
                desc_word[`RTMC_DESC_DPB]   <= ~desc_r[`RTMC_DESC_DPB];
                desc_word[`RTMC_DESC_DESCRIPTOR_ACCESSED_FLAG]  <= (outcome != RTMC_OUT_DEFAULT);
                desc_word[`RTMC_DESC_BROADCAST_FLAG] <= (outcome != RTMC_OUT_TRAIL) && broadcast_flag;
                desc_wr     <= 1'b1;
                msg_info_wr <= 1'b1;
                msg_info_word <= `RTMC_ZERO16;
                msg_info_word[`RTMC_MI_RECEIVING_BUS_FLAG]  <= cmd_bus_b;
                msg_info_word[`RTMC_MI_MESSAGE_ERROR_FLAG]   <= (outcome == RTMC_OUT_ILLEGAL) || (outcome == RTMC_OUT_TRAIL);
                msg_info_word[`RTMC_MI_ILLEGAL_COMMAND_FLAG]  <= (outcome == RTMC_OUT_ILLEGAL);
                msg_info_word[`RTMC_MI_WORD_COUNT_ERROR_FLAG] <= (outcome == RTMC_OUT_TRAIL);
                message_complete_irq <= 1'b1;
                broadcast_msg_irq    <= broadcast_flag && (outcome != RTMC_OUT_TRAIL);
                illegal_command_irq  <= (outcome == RTMC_OUT_ILLEGAL);
                message_error_irq    <= (outcome == RTMC_OUT_TRAIL);
            end
        end
    end

    // Register readback.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata        <= `RTMC_ZERO16;
            rt_reset_pending <= 1'b0;
        end else begin
            rt_reset_pending <= reset_wait_r;
            case (reg_addr)
                `RTMC_OFS_STATUS_BITS: reg_rdata <= status_bits_r;
                `RTMC_OFS_BIT_WORD:    reg_rdata <= bit_word_r;
                `RTMC_OFS_CONFIG:      reg_rdata <= config_r;
                default:               reg_rdata <= `RTMC_ZERO16;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rtmc_bc_model.sv ***
// Bus controller stand-in that reports when a requested status word has gone out.
`timescale 1ns/1ps
`default_nettype none
module rtmc_bc_model #(
    parameter int DLY = 1
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Status transmit handshake
    input  wire logic status_tx_req,
    output logic      status_sent
);
    int cnt_r;
    // A larger delay models a slow transmitter, so clears after status are not seen too early.
    always_ff @(posedge sys_clk) begin
        if (sys_rst || status_tx_req) begin
            cnt_r <= sys_rst ? 0 : DLY;
        end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
        end
        status_sent <= !sys_rst && cnt_r == 1;
    end
endmodule
`default_nettype wire

// *** rtmc_chk.sv ***
// Concurrent checks on the mode command handler ports.
`timescale 1ns/1ps
`default_nettype none
module rtmc_chk (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        cmd_valid,
    input wire logic        cmd_error,
    input wire logic [4:0]  cmd_rt_addr,
    input wire logic        cmd_tr,
    input wire logic [4:0]  cmd_mode_code,
    input wire logic        cmd_trailing_data,
    input wire logic        cmd_illegal_bit,
    input wire logic [4:0]  own_rt_addr,
    input wire logic        status_tx_req,
    input wire logic [15:0] status_word,
    input wire logic        desc_wr,
    input wire logic [15:0] desc_word,
    input wire logic        msg_info_wr,
    input wire logic [15:0] msg_info_word,
    input wire logic        illegal_command_irq,
    input wire logic        tx_shutdown_a,
    input wire logic        tx_shutdown_b
);
    logic hit;
    logic dflt;
    assign hit = cmd_valid && !cmd_error && (cmd_mode_code == 5'h07 || cmd_mode_code == 5'h08)
        && (cmd_rt_addr == own_rt_addr || cmd_rt_addr == 5'h1f);
    assign dflt = hit && cmd_tr && !cmd_trailing_data;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_own_status; dflt && cmd_rt_addr == own_rt_addr |=> status_tx_req; endproperty
    property p_broadcast_flag_quiet; hit && cmd_rt_addr == 5'h1f |=> !status_tx_req; endproperty
    property p_me_clear; dflt |=> ##1 !status_word[10]; endproperty
    property p_default_info;
        dflt |=> msg_info_wr && desc_wr && !desc_word[0] && msg_info_word[4:1] == 4'h0;
    endproperty
    property p_trail;
        hit && cmd_trailing_data |=> msg_info_wr && !status_tx_req && msg_info_word[4:1] == 4'h9 && !desc_word[1];
    endproperty
    property p_ignore; cmd_valid && !hit |=> !msg_info_wr && !desc_wr && !status_tx_req; endproperty
    property p_illegal; illegal_command_irq |-> $past(hit && !cmd_tr && cmd_illegal_bit); endproperty
    property p_shut; dflt && cmd_mode_code == 5'h08 |=> !tx_shutdown_a && !tx_shutdown_b; endproperty
    a_own_status: assert property (p_own_status) else $error("no status for own command");
    a_broadcast_flag_quiet: assert property (p_broadcast_flag_quiet) else $error("status sent on broadcast");
    a_me_clear: assert property (p_me_clear) else $error("ME not cleared");
    a_default_info: assert property (p_default_info) else $error("bad default update");
    a_trail: assert property (p_trail) else $error("bad trailing word handling");
    a_ignore: assert property (p_ignore) else $error("response to foreign command");
    a_illegal: assert property (p_illegal) else $error("stray illegal interrupt");
    a_shut: assert property (p_shut) else $error("shutdown kept after reset");
    c_broadcast_flag: cover property (hit && cmd_rt_addr == 5'h1f);
    c_trail: cover property (hit && cmd_trailing_data);
    c_illegal: cover property (illegal_command_irq);
endmodule
bind rtmc_modecode rtmc_chk rtmc_chk_i (.sys_clk, .sys_rst, .cmd_valid, .cmd_error, .cmd_rt_addr, .cmd_tr,
    .cmd_mode_code, .cmd_trailing_data, .cmd_illegal_bit, .own_rt_addr, .status_tx_req, .status_word, .desc_wr,
    .desc_word, .msg_info_wr, .msg_info_word, .illegal_command_irq, .tx_shutdown_a, .tx_shutdown_b);
`default_nettype wire

// *** rtmc_modecode_bench.sv ***
// Self-checking bench for the flag-override and reset mode command handler.
`timescale 1ns/1ps
`default_nettype none
`include "rtmc_defs.svh"
module rtmc_modecode_bench;
    typedef struct packed {
        logic [4:0] a; logic tr; logic [4:0] mc; logic tl, il, bb, er, req, wr;
        logic [15:0] mi; logic [1:0] d;
    } rtmc_row_t;
    // Address, T/R, mode code, trailing, illegal, bus B, error; then status, info write, info, {BROADCAST_FLAG,DESCRIPTOR_ACCESSED_FLAG}.
    rtmc_row_t rows [9] = '{
        '{5'h05, 1'h1, 5'h07, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 16'h0000, 2'h0},
        '{5'h1f, 1'h1, 5'h07, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 16'h0001, 2'h2},
        '{5'h05, 1'h0, 5'h07, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 16'h0000, 2'h1},
        '{5'h05, 1'h0, 5'h08, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 16'h0007, 2'h1},
        '{5'h05, 1'h1, 5'h07, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 16'h0012, 2'h1},
        '{5'h1f, 1'h1, 5'h08, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 16'h0012, 2'h1},
        '{5'h05, 1'h1, 5'h08, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 16'h0000, 2'h0},
        '{5'h06, 1'h1, 5'h07, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0000, 2'h0},
        '{5'h05, 1'h1, 5'h07, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 16'h0000, 2'h0}};
    logic sys_clk = 1'h0, sys_rst = 1'h1, cmd_valid = 1'h0, cmd_error = 1'h0, cmd_tr = 1'h0, reg_wr = 1'h0;
    logic cmd_trailing_data = 1'h0, cmd_bus_b = 1'h0, cmd_illegal_bit = 1'h0, tf_inhibit_set = 1'h0;
    logic shutdown_set_a = 1'h0, shutdown_set_b = 1'h0, busy_set = 1'h0, buffer_pointer_toggle = 1'h0;
    logic [4:0] cmd_rt_addr = 5'h00, cmd_mode_code = 5'h00, own_rt_addr = 5'h05;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, status_word, desc_word, msg_info_word;
    logic status_sent, status_tx_req, desc_wr, msg_info_wr, message_complete_irq, broadcast_msg_irq;
    logic illegal_command_irq, message_error_irq, tx_shutdown_a, tx_shutdown_b, rt_reset_pending;
    int error_cnt = 0, num_checks = 0;
    rtmc_modecode rtmc_modecode_i (.sys_clk, .sys_rst, .cmd_valid, .cmd_error, .cmd_rt_addr, .cmd_tr,
        .cmd_mode_code, .cmd_trailing_data, .cmd_bus_b, .cmd_illegal_bit, .own_rt_addr, .status_sent,
        .tf_inhibit_set, .shutdown_set_a, .shutdown_set_b, .busy_set, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .status_tx_req, .status_word, .desc_wr, .desc_word, .msg_info_wr, .msg_info_word, .message_complete_irq,
        .broadcast_msg_irq, .illegal_command_irq, .message_error_irq, .tx_shutdown_a, .tx_shutdown_b,
        .rt_reset_pending);
    rtmc_bc_model #(.DLY(3)) rtmc_bc_model_i (.sys_clk, .sys_rst, .status_tx_req, .status_sent);
    always #5 sys_clk = ~sys_clk;
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic send(input rtmc_row_t r);
        {cmd_rt_addr, cmd_tr, cmd_mode_code, cmd_trailing_data} = {r.a, r.tr, r.mc, r.tl};
        {cmd_illegal_bit, cmd_bus_b, cmd_error} = {r.il, r.bb, r.er};
        cmd_valid = 1'h1;
        tick();
        cmd_valid = 1'h0;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        {reg_wr, reg_addr, reg_wdata} = {1'h1, a, d};
        tick();
        reg_wr = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_addr = a;
        tick();
        chk(reg_rdata, e);
    endtask
    task automatic final_report;
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #50000;
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (16) tick();
        sys_rst = 1'h0;
        foreach (rows[i]) begin
            send(rows[i]);
            chk(status_tx_req, rows[i].req);
            chk(msg_info_wr, rows[i].wr);
            chk({desc_wr, message_complete_irq, broadcast_msg_irq, message_error_irq, illegal_command_irq},
                {rows[i].wr, rows[i].wr, rows[i].wr && rows[i].a == 5'h1f && !rows[i].tl, rows[i].tl,
                 rows[i].wr && rows[i].il && !rows[i].tr && !rows[i].tl});
            if (rows[i].wr) begin
                buffer_pointer_toggle = !buffer_pointer_toggle;
                chk(msg_info_word, rows[i].mi);
                chk(desc_word, {13'h0000, buffer_pointer_toggle, rows[i].d});
            end
            repeat (6) tick();
        end
        wr_reg(`RTMC_OFS_STATUS_BITS, 16'h0001);
        tf_inhibit_set = 1'h1;
        tick();
        tf_inhibit_set = 1'h0;
        rd(`RTMC_OFS_BIT_WORD, 16'h0001);
        send(rows[0]);
        repeat (4) tick();
        rd(`RTMC_OFS_BIT_WORD, 16'h0000);
        send(rows[0]);
        chk(status_word[0], 1'h1);
        wr_reg(`RTMC_OFS_CONFIG, 16'h0001);
        send(rows[3]);
        chk({status_tx_req, msg_info_wr, illegal_command_irq}, 3'h0);
        {shutdown_set_a, shutdown_set_b, busy_set, tf_inhibit_set} = 4'hf;
        tick();
        {shutdown_set_a, shutdown_set_b, busy_set, tf_inhibit_set} = 4'h0;
        tick();
        chk({tx_shutdown_a, tx_shutdown_b}, 2'h3);
        send(rows[6]);
        chk(status_word[3], 1'h1);
        tick();
        chk(rt_reset_pending, 1'h1);
        repeat (7) tick();
        chk({tx_shutdown_a, tx_shutdown_b}, 2'h0);
        rd(`RTMC_OFS_BIT_WORD, 16'h0000);
        rd(`RTMC_OFS_CONFIG, 16'h0001);
        rd(8'h00, 16'h0000);
        send(rows[0]);
        chk(status_word & 16'h0418, 16'h0000);
        tf_inhibit_set = 1'h1;
        tick();
        tf_inhibit_set = 1'h0;
        rd(`RTMC_OFS_BIT_WORD, 16'h0001);
        wr_reg(`RTMC_OFS_CONFIG, 16'h0003);
        rd(`RTMC_OFS_BIT_WORD, 16'h0000);
        repeat (4) tick();
        final_report();
    end
endmodule
`default_nettype wire
